/* core/pfail_pkg.sv */
// constants, types and register map for the power-fail timekeeping block
// assumes a 20 MHz core clock and a host bus sampled synchronously
//
// Behaviour
// - power fail drops nmi until hold drops
// - hold line drops 3 ms after nmi
// - hold released 150 ms after restore
// - tick and serial requests share irq
// - one tick per mains cycle, late phase
// - tick flag status bit 8, write clears
// - two machine cycle times, jumper selected
// - restart output rests high, starts at nmi
// - 1.75 s outage drops restart output
// - short outage clears restart count
// - downtime counts nmi low to hold high
// - minutes and seconds, eight bits each
// - minutes saturate at 255
// - write to 5000 clears downtime
// - minutes at 5000, seconds at 500f
// - seconds 0..59 then minutes step
// - ground-true ports, rw selects direction
// - 80 latched open-collector output bits
// - outputs open at reset and power fail
// - 64 gated inputs, ground reads one
// - status layout bits 1 to 8
// - status bit 6 shows address config
package pfail_pkg;

   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned CLK_KHZ        = CLK_HZ / 1000;
   localparam int unsigned HOLD_DELAY_MS  = 3;
   localparam int unsigned RESTORE_MS     = 150;
   localparam int unsigned RESTART_MS     = 1750;
   localparam int unsigned RESTART_END_MS = 50;
   localparam int unsigned MS_PER_SEC     = 1000;
   localparam int unsigned SEC_PER_MIN    = 60;
   localparam int unsigned MINUTES_MAX    = 255;
   // mains phase window, degrees
   localparam int unsigned PHASE_LO_DEG   = 270;
   localparam int unsigned PHASE_HI_DEG   = 330;
   localparam int unsigned PHASE_MID_DEG  = (PHASE_LO_DEG + PHASE_HI_DEG) / 2;
   localparam int unsigned DEG_PER_CYCLE  = 360;
   localparam int unsigned MAINS_HZ       = 60;
   localparam int unsigned TICK_DELAY_US  =
      PHASE_MID_DEG * 1_000_000 / (DEG_PER_CYCLE * MAINS_HZ);
   localparam int unsigned TICK_DELAY_CYC = TICK_DELAY_US * (CLK_HZ / 1_000_000);
   // machine cycle times in ps
   localparam int unsigned CYC_FAST_PS    = 651_000;
   localparam int unsigned CYC_SLOW_PS    = 1_302_000;
   localparam int unsigned CLK_PS         = 1_000_000_000 / (CLK_HZ / 1000);
   localparam int unsigned CYC_FAST_CLKS  = CYC_FAST_PS / CLK_PS;
   localparam int unsigned CYC_SLOW_CLKS  = CYC_SLOW_PS / CLK_PS;

   localparam logic [15:0] ADDR_MINUTES   = 16'h5000;
   localparam logic [15:0] ADDR_SECONDS   = 16'h500f;
   localparam logic [15:0] ADDR_STATUS    = 16'h5fff;
   localparam logic [15:0] ADDR_OUT_BASE  = 16'h5001;
   localparam logic [15:0] ADDR_IN_BASE   = 16'h5001;

   localparam int unsigned OUT_BYTES      = 10;
   localparam int unsigned IN_BYTES       = 8;

   // status bit positions, bit 1 of the map is index 0
   localparam int unsigned ST_SERIAL_LSB  = 0;
   localparam int unsigned ST_CONFIG      = 5;
   localparam int unsigned ST_TIMEOUT     = 6;
   localparam int unsigned ST_TICK        = 7;

   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_FAIL_WAIT,
      PWR_HELD,
      PWR_RESTORE
   } pwr_state_e;

   typedef struct packed {
      logic [15:0] addr;
      logic        valid;
      logic        rw;
      logic [7:0]  wdata;
   } host_req_s;

endpackage

/* core/power_fail_timekeeping.sv */
// power-fail sequencer, restart timer, downtime counter, tick and ports
// assumes all inputs are synchronous to core_clk except power indications
`timescale 1ns/100ps
`default_nettype none
module power_fail_timekeeping
   import pfail_pkg::*;
#(
   parameter int unsigned OUT_BYTES_P = OUT_BYTES,
   parameter int unsigned IN_BYTES_P  = IN_BYTES,
   parameter int unsigned MS_CLKS     = CLK_KHZ,
   parameter int unsigned TICK_CLKS   = TICK_DELAY_CYC
) (
   input  wire logic                       core_clk,
   input  wire logic                       reset_n,
   input  wire logic                       power_ok,
   input  wire logic                       mains_zero_cross,
   input  wire logic [3:0]                 serial_irq,
   input  wire logic                       addr_config_two,
   input  wire logic                       cycle_jumper_in,
   input  wire pfail_pkg::host_req_s       host_req,
   input  wire logic [IN_BYTES_P*8-1:0]    input_pins_n,
   output logic                            nmi_n,
   output logic                            startup_hold_n,
   output logic                            restart_n,
   output logic                            shared_irq_n,
   output logic                            machine_cycle_en,
   output logic [7:0]                      rdata,
   output logic                            rdata_oe,
   output logic [OUT_BYTES_P*8-1:0]        output_sink
);
   import pfail_pkg::*;

   // ---------------------------------------------------------------
   // synchronisers
   // ---------------------------------------------------------------
   logic pok_meta_r, pok_r, zc_meta_r, zc_r, zc_d_r;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pok_meta_r <= 1'b0;
         pok_r      <= 1'b0;
         zc_meta_r  <= 1'b0;
         zc_r       <= 1'b0;
         zc_d_r     <= 1'b0;
      end else begin
         pok_meta_r <= power_ok;
         pok_r      <= pok_meta_r;
         zc_meta_r  <= mains_zero_cross;
         zc_r       <= zc_meta_r;
         zc_d_r     <= zc_r;
      end
   end

   // ---------------------------------------------------------------
   // millisecond time base
   // ---------------------------------------------------------------
   logic [15:0] ms_div_r;
   logic        ms_en;

   assign ms_en = (ms_div_r == 16'(MS_CLKS - 1));

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ms_div_r <= '0;
      end else if (ms_en) begin
         ms_div_r <= '0;
      end else begin
         ms_div_r <= ms_div_r + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // power sequencer
   // ---------------------------------------------------------------
   pwr_state_e  pwr_r;
   logic [7:0]  seq_ms_r;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pwr_r          <= PWR_HELD;
         seq_ms_r       <= '0;
         nmi_n          <= 1'b1;
         startup_hold_n <= 1'b0;
      end else begin
         unique case (pwr_r)
            PWR_RUN: begin
               if (!pok_r) begin
                  nmi_n    <= 1'b0;
                  seq_ms_r <= '0;
                  pwr_r    <= PWR_FAIL_WAIT;
               end
            end
            PWR_FAIL_WAIT: begin
               if (ms_en) begin
                  seq_ms_r <= seq_ms_r + 8'h01;
               end
               if (ms_en && seq_ms_r == 8'(HOLD_DELAY_MS - 1)) begin
                  startup_hold_n <= 1'b0;
                  nmi_n          <= 1'b1;
                  seq_ms_r       <= '0;
                  pwr_r          <= PWR_HELD;
               end
            end
            PWR_HELD: begin
               if (pok_r) begin
                  seq_ms_r <= '0;
                  pwr_r    <= PWR_RESTORE;
               end
            end
            PWR_RESTORE: begin
               if (!pok_r) begin
                  pwr_r <= PWR_HELD;
               end else if (ms_en) begin
                  seq_ms_r <= seq_ms_r + 8'h01;
                  if (seq_ms_r == 8'(RESTORE_MS - 1)) begin
                     startup_hold_n <= 1'b1;
                     pwr_r          <= PWR_RUN;
                  end
               end
            end
         endcase
      end
   end

   // outage spans nmi fall to hold release
   logic outage;
   assign outage = (pwr_r != PWR_RUN);

   // ---------------------------------------------------------------
   // restart timer
   // ---------------------------------------------------------------
   logic [10:0] rst_ms_r;
   logic        timed_out_r;
   logic [5:0]  end_ms_r;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_ms_r    <= '0;
         timed_out_r <= 1'b0;
         end_ms_r    <= '0;
         restart_n   <= 1'b1;
      end else if (outage) begin
         end_ms_r <= '0;
         if (ms_en && !timed_out_r) begin
            rst_ms_r <= rst_ms_r + 11'h001;
            if (rst_ms_r == 11'(RESTART_MS - 1)) begin
               timed_out_r <= 1'b1;
               restart_n   <= 1'b0;
            end
         end
      end else begin
         // short outage leaves high, count zeroed
         rst_ms_r <= '0;
         if (timed_out_r && ms_en) begin
            end_ms_r <= end_ms_r + 6'h01;
            // release 50 ms after hold high
            if (end_ms_r == 6'(RESTART_END_MS - 1)) begin
               timed_out_r <= 1'b0;
               restart_n   <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // downtime counter
   // ---------------------------------------------------------------
   logic [9:0] sec_ms_r;
   logic [7:0] minutes_r, seconds_r;
   logic       clr_dt;

   assign clr_dt = host_req.valid && !host_req.rw && host_req.addr == ADDR_MINUTES;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sec_ms_r  <= '0;
         minutes_r <= '0;
         seconds_r <= '0;
      end else if (clr_dt) begin
         sec_ms_r  <= '0;
         minutes_r <= '0;
         seconds_r <= '0;
      end else if (outage && ms_en && minutes_r != 8'(MINUTES_MAX)) begin
         if (sec_ms_r == 10'(MS_PER_SEC - 1)) begin
            sec_ms_r <= '0;
            if (seconds_r == 8'(SEC_PER_MIN - 1)) begin
               seconds_r <= '0;
               minutes_r <= minutes_r + 8'h01;
            end else begin
               seconds_r <= seconds_r + 8'h01;
            end
         end else begin
            sec_ms_r <= sec_ms_r + 10'h001;
         end
      end
   end

   // ---------------------------------------------------------------
   // mains tick
   // ---------------------------------------------------------------
   logic [19:0] tick_cnt_r;
   logic        tick_arm_r, tick_flag_r, tick_fire, clr_tick;

   assign tick_fire = tick_arm_r && tick_cnt_r == 20'(TICK_CLKS - 1);
   assign clr_tick  = host_req.valid && !host_req.rw && host_req.addr == ADDR_STATUS;

   // delay from rising crossing into late phase
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt_r <= '0;
         tick_arm_r <= 1'b0;
      end else if (zc_r && !zc_d_r) begin
         tick_cnt_r <= '0;
         tick_arm_r <= 1'b1;
      end else if (tick_fire) begin
         tick_arm_r <= 1'b0;
      end else if (tick_arm_r) begin
         tick_cnt_r <= tick_cnt_r + 20'h00001;
      end
   end

   // sticky until host write, set wins
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_flag_r <= 1'b0;
      end else if (tick_fire) begin
         tick_flag_r <= 1'b1;
      end else if (clr_tick) begin
         tick_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         shared_irq_n <= 1'b1;
      end else begin
         shared_irq_n <= !(tick_flag_r || tick_fire || (|serial_irq));
      end
   end

   // ---------------------------------------------------------------
   // machine cycle enable
   // ---------------------------------------------------------------
   logic [5:0] mc_div_r;
   logic [5:0] mc_last;

   assign mc_last = cycle_jumper_in ? 6'(CYC_SLOW_CLKS - 1) : 6'(CYC_FAST_CLKS - 1);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mc_div_r         <= '0;
         machine_cycle_en <= 1'b0;
      end else begin
         machine_cycle_en <= (mc_div_r >= mc_last);
         mc_div_r         <= (mc_div_r >= mc_last) ? '0 : mc_div_r + 6'h01;
      end
   end

   // ---------------------------------------------------------------
   // output latches
   // ---------------------------------------------------------------
   logic [OUT_BYTES_P*8-1:0] out_latch_r;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_latch_r <= '0;
         output_sink <= '0;
      end else begin
         for (int i = 0; i < OUT_BYTES_P; i++) begin
            if (host_req.valid && !host_req.rw &&
                host_req.addr == ADDR_OUT_BASE + 16'(i)) begin
               out_latch_r[i*8 +: 8] <= host_req.wdata;
            end
         end
         output_sink <= pok_r ? out_latch_r : '0;
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   logic [7:0] rd_nxt;
   logic       rd_hit;
   logic [7:0] status;

   assign status = {tick_flag_r, timed_out_r, addr_config_two, 1'b0, serial_irq};

   always_comb begin
      rd_nxt = 8'h00;
      rd_hit = 1'b0;
      if (host_req.valid && host_req.rw) begin
         if (host_req.addr == ADDR_MINUTES) begin
            rd_nxt = minutes_r;
            rd_hit = 1'b1;
         end else if (host_req.addr == ADDR_SECONDS) begin
            rd_nxt = seconds_r;
            rd_hit = 1'b1;
         end else if (host_req.addr == ADDR_STATUS) begin
            rd_nxt = status;
            rd_hit = 1'b1;
         end else begin
            for (int i = 0; i < IN_BYTES_P; i++) begin
               if (host_req.addr == ADDR_IN_BASE + 16'(i)) begin
                  rd_nxt = ~input_pins_n[i*8 +: 8];
                  rd_hit = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata    <= 8'h00;
         rdata_oe <= 1'b0;
      end else begin
         rdata    <= rd_nxt;
         rdata_oe <= rd_hit;
      end
   end

endmodule
`default_nettype wire

/* verification/power_fail_timekeeping_sva.sv */
// checker: power sequencing, restart timing, bus answers, outputs
// assumes binding to the block; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module power_fail_timekeeping_sva
#(
   parameter int unsigned OUT_BYTES_P = pfail_pkg::OUT_BYTES,
   parameter int unsigned MS_CLKS     = pfail_pkg::CLK_KHZ
) (
   input wire logic                     core_clk,
   input wire logic                     reset_n,
   input wire logic                     power_ok,
   input wire logic [3:0]               serial_irq,
   input wire pfail_pkg::host_req_s     host_req,
   input wire logic                     nmi_n,
   input wire logic                     startup_hold_n,
   input wire logic                     restart_n,
   input wire logic                     shared_irq_n,
   input wire logic                     machine_cycle_en,
   input wire logic [7:0]               rdata,
   input wire logic                     rdata_oe,
   input wire logic [OUT_BYTES_P*8-1:0] output_sink
);
   import pfail_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // -------------------------------------
   // cycle counters: power good, outage, hold high, pulse gap
   // -------------------------------------
   int unsigned ok_c;
   int unsigned out_c;
   int unsigned hi_c;
   int unsigned mc_c;
   // divider restarts on the first edge out of reset
   logic        run_r;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ok_c  <= 0;
         out_c <= 0;
         hi_c  <= 0;
         mc_c  <= 0;
         run_r <= 1'b0;
      end else begin
         ok_c  <= power_ok ? ok_c + 1 : 0;
         out_c <= (nmi_n && startup_hold_n) ? 0 : out_c + 1;
         hi_c  <= startup_hold_n ? hi_c + 1 : 0;
         mc_c  <= (machine_cycle_en || !run_r) ? 0 : mc_c + 1;
         run_r <= 1'b1;
      end
   end
   // -------------------------------------
   // properties
   // -------------------------------------
   nmi_on_fail_a: assert property (
      $fell(power_ok) && nmi_n && startup_hold_n |-> ##[2:4] !nmi_n)
      else $error("nmi missed power loss");
   nmi_release_a: assert property (
      $rose(nmi_n) |-> $fell(startup_hold_n)) else $error("nmi released early");
   hold_delay_a: assert property (
      $fell(nmi_n) |-> ##[38:62] $fell(startup_hold_n)) else $error("hold delay wrong");
   hold_release_a: assert property (
      $rose(startup_hold_n) |-> ok_c >= (RESTORE_MS-1)*MS_CLKS
         && ok_c <= RESTORE_MS*MS_CLKS+8) else $error("hold release time wrong");
   restart_fall_a: assert property (
      $fell(restart_n) |-> out_c >= (RESTART_MS-1)*MS_CLKS
         && out_c <= (RESTART_MS+1)*MS_CLKS) else $error("restart fell off time");
   restart_end_a: assert property (
      $rose(restart_n) |-> hi_c >= (RESTART_END_MS-1)*MS_CLKS
         && hi_c <= (RESTART_END_MS+1)*MS_CLKS) else $error("restart rose off time");
   restart_rest_a: assert property (
      hi_c > (RESTART_END_MS+2)*MS_CLKS |-> restart_n) else $error("restart not high");
   irq_serial_a: assert property (
      |serial_irq |=> !shared_irq_n) else $error("serial request not on irq");
   read_answer_a: assert property (
      host_req.valid && host_req.rw && host_req.addr == ADDR_STATUS |=> rdata_oe)
      else $error("no read answer");
   unmapped_a: assert property (
      host_req.valid && host_req.rw && host_req.addr == 16'h4000
         |=> !rdata_oe && rdata == 8'h00) else $error("unmapped read answered");
   outputs_open_a: assert property (
      !nmi_n && !$past(nmi_n) |-> output_sink == '0) else $error("outputs not open");
   cycle_gap_a: assert property (
      mc_c <= 25) else $error("machine cycle gap too long");
endmodule
bind power_fail_timekeeping power_fail_timekeeping_sva #(
   .OUT_BYTES_P(OUT_BYTES_P), .MS_CLKS(MS_CLKS)) chk_u (
   .core_clk(core_clk), .reset_n(reset_n), .power_ok(power_ok),
   .serial_irq(serial_irq), .host_req(host_req), .nmi_n(nmi_n),
   .startup_hold_n(startup_hold_n), .restart_n(restart_n),
   .shared_irq_n(shared_irq_n), .machine_cycle_en(machine_cycle_en),
   .rdata(rdata), .rdata_oe(rdata_oe), .output_sink(output_sink));
`default_nettype wire

/* verification/host_bus_model.sv */
// host processor model: one-cycle requests on the block's bus
// assumes read data stands one edge after the request is taken
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
   input  wire logic                 core_clk,
   input  wire logic [7:0]           rdata,
   input  wire logic                 rdata_oe,
   output var  pfail_pkg::host_req_s host_req
);
   import pfail_pkg::*;
   initial host_req = '0;
   // idle bus shows inverted lines, not the last value
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      host_req <= '{addr: a, valid: 1'b1, rw: 1'b0, wdata: d};
      @(posedge core_clk);
      host_req <= '{addr: ~a, valid: 1'b0, rw: 1'b1, wdata: ~d};
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe);
      @(posedge core_clk);
      host_req <= '{addr: a, valid: 1'b1, rw: 1'b1, wdata: 8'h00};
      @(posedge core_clk);
      host_req <= '{addr: ~a, valid: 1'b0, rw: 1'b0, wdata: 8'hff};
      // answer stands until the next edge; take it there
      @(posedge core_clk);
      d = rdata;
      oe = rdata_oe;
   endtask
endmodule
`default_nettype wire

/* verification/power_fail_timekeeping_tb_top.sv */
// testbench: host tasks drive the block, expectations from the rules
// assumes the bound checker and a shortened millisecond count
`timescale 1ns/100ps
`default_nettype none
module power_fail_timekeeping_tb_top;
   import pfail_pkg::*;
   logic        core_clk;
   logic        reset_n;
   logic        power_ok;
   logic        mains_zero_cross;
   logic        addr_config_two;
   logic        cycle_jumper_in;
   logic [3:0]  serial_irq;
   logic [63:0] input_pins_n;
   host_req_s   host_req;
   logic        nmi_n;
   logic        startup_hold_n;
   logic        restart_n;
   logic        shared_irq_n;
   logic        machine_cycle_en;
   logic        rdata_oe;
   logic        oe;
   logic [7:0]  rdata;
   logic [7:0]  d;
   logic [79:0] output_sink;
   int          err_count;
   int          num_checks;
   int          cyc;
   power_fail_timekeeping #(.MS_CLKS(20), .TICK_CLKS(100)) dut_u (
      .core_clk(core_clk), .reset_n(reset_n), .power_ok(power_ok),
      .mains_zero_cross(mains_zero_cross), .serial_irq(serial_irq),
      .addr_config_two(addr_config_two), .cycle_jumper_in(cycle_jumper_in),
      .host_req(host_req), .input_pins_n(input_pins_n), .nmi_n(nmi_n),
      .startup_hold_n(startup_hold_n), .restart_n(restart_n),
      .shared_irq_n(shared_irq_n), .machine_cycle_en(machine_cycle_en),
      .rdata(rdata), .rdata_oe(rdata_oe), .output_sink(output_sink));
   host_bus_model host_u (.core_clk(core_clk), .rdata(rdata), .rdata_oe(rdata_oe),
      .host_req(host_req));
   initial core_clk = 1'b0;
   always #25 core_clk = ~core_clk;
   // -------------------------------------
   // compare and wait helpers
   // -------------------------------------
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_byte({7'h00, g}, {7'h00, e});
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      host_u.rd(a, d, oe);
      chk_bit(oe, 1'b1);
      chk_byte(d, e);
   endtask
   // bounded wait; a long outage plus restore fits well inside
   task automatic wait_hold(input logic v);
      for (int i = 0; i < 50000 && startup_hold_n !== v; i++) @(posedge core_clk);
      chk_bit(startup_hold_n, v);
   endtask
   task automatic mc_per(input logic j, input int e);
      int n;
      @(posedge core_clk) cycle_jumper_in <= j;
      repeat (60) @(negedge core_clk);
      while (machine_cycle_en !== 1'b1) @(negedge core_clk);
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (machine_cycle_en !== 1'b1 && n < 40);
      chk_byte(8'(n), 8'(e));
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 80000) begin
         err_count++;
         test_done();
      end
   end
   // -------------------------------------
   // test sequence
   // -------------------------------------
   initial begin
      reset_n = 1'b0;
      power_ok = 1'b1;
      mains_zero_cross = 1'b0;
      addr_config_two = 1'b0;
      cycle_jumper_in = 1'b1;
      serial_irq = 4'h0;
      input_pins_n = '1;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      chk_bit(output_sink === 80'h0, 1'b1);
      wait_hold(1'b1);
      chk_bit(restart_n, 1'b1);
      $display("test startup done");
      for (int i = 0; i < 10; i++) host_u.wr(16'h5001 + 16'(i), 8'(17 * (i + 1)));
      repeat (2) @(posedge core_clk);
      for (int i = 0; i < 10; i++) chk_byte(output_sink[i*8 +: 8], 8'(17 * (i + 1)));
      @(posedge core_clk) input_pins_n <= 64'h0123_4567_89ab_cdef;
      repeat (4) @(posedge core_clk);
      for (int i = 0; i < 8; i++) rd_chk(16'h5001 + 16'(i), ~input_pins_n[i*8 +: 8]);
      host_u.rd(16'h4000, d, oe);
      chk_bit(oe, 1'b0);
      chk_byte(d, 8'h00);
      $display("test ports done");
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk);
         serial_irq <= k ? 4'ha : 4'h5;
         addr_config_two <= k[0];
         repeat (4) @(posedge core_clk);
         rd_chk(ADDR_STATUS, {2'b00, k[0], 1'b0, k ? 4'ha : 4'h5});
         chk_bit(shared_irq_n, 1'b0);
      end
      @(posedge core_clk);
      serial_irq <= 4'h0;
      addr_config_two <= 1'b0;
      repeat (4) @(posedge core_clk);
      chk_bit(shared_irq_n, 1'b1);
      mc_per(1'b1, 26);
      mc_per(1'b0, 13);
      $display("test status done");
      @(posedge core_clk) mains_zero_cross <= 1'b1;
      repeat (60) @(posedge core_clk);
      rd_chk(ADDR_STATUS, 8'h00);
      repeat (60) @(posedge core_clk);
      rd_chk(ADDR_STATUS, 8'h80);
      @(posedge core_clk) mains_zero_cross <= 1'b0;
      repeat (200) @(posedge core_clk);
      chk_bit(shared_irq_n, 1'b0);
      host_u.wr(ADDR_STATUS, 8'h00);
      repeat (2) @(posedge core_clk);
      chk_bit(shared_irq_n, 1'b1);
      rd_chk(ADDR_STATUS, 8'h00);
      $display("test tick done");
      @(posedge core_clk) power_ok <= 1'b0;
      wait_hold(1'b0);
      chk_bit(output_sink === 80'h0, 1'b1);
      @(posedge core_clk) power_ok <= 1'b1;
      wait_hold(1'b1);
      chk_bit(restart_n, 1'b1);
      rd_chk(ADDR_STATUS, 8'h00);
      host_u.wr(ADDR_MINUTES, 8'h5a);
      rd_chk(ADDR_SECONDS, 8'h00);
      $display("test short outage done");
      @(posedge core_clk) power_ok <= 1'b0;
      repeat (41000) @(posedge core_clk);
      chk_bit(restart_n, 1'b0);
      @(posedge core_clk) power_ok <= 1'b1;
      wait_hold(1'b1);
      chk_bit(restart_n, 1'b0);
      rd_chk(ADDR_STATUS, 8'h40);
      rd_chk(ADDR_SECONDS, 8'h02);
      rd_chk(ADDR_MINUTES, 8'h00);
      repeat (1200) @(posedge core_clk);
      chk_bit(restart_n, 1'b1);
      host_u.wr(ADDR_MINUTES, 8'hff);
      rd_chk(ADDR_SECONDS, 8'h00);
      $display("test long outage done");
      test_done();
   end
endmodule
`default_nettype wire
